/* File: jpd_pkg.sv */
/*
 * jpd_pkg: constants and types shared by the test-port programming
 * data registers and their two-entry output buffer.
 * assumes: nothing beyond a SystemVerilog elaborator.
 */
package jpd_pkg;

    // ----------------------------------------------------------------
    // instruction codes
    // ----------------------------------------------------------------
    localparam int IR_W = 4;
    localparam logic [3:0] IR_DEVICE_RESET = 4'hC;
    localparam logic [3:0] IR_UNLOCK = 4'h4;
    localparam logic [3:0] IR_COMMAND = 4'h5;
    localparam logic [3:0] IR_PAGE_LOAD = 4'h6;
    localparam logic [3:0] IR_PAGE_READ = 4'h7;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;

    // ----------------------------------------------------------------
    // data register widths and values
    // ----------------------------------------------------------------
    localparam int ENABLE_W = 16;
    localparam int CMD_W = 15;
    localparam int BYTE_W = 8;
    localparam int PAGE_BITS = 1024;
    localparam int PAGE_BYTES = PAGE_BITS / BYTE_W;
    localparam int PAGE_READ_BITS = PAGE_BITS + BYTE_W;
    localparam int IDX_W = $clog2(PAGE_BYTES);
    localparam int BIT_CNT_W = $clog2(BYTE_W);
    localparam int LOAD_W = IDX_W + BYTE_W;
    localparam logic [15:0] UNLOCK_SIGNATURE = 16'hA370;
    localparam logic [15:0] ENABLE_RST = 16'h0000;
    localparam logic [14:0] CMD_RST = 15'h0000;
    localparam logic [7:0] READ_FILL_BYTE = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int SYNC_STAGES = 2;

    // ----------------------------------------------------------------
    // test access port states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0,
        TAP_IDLE = 4'h1,
        TAP_SEL_DR = 4'h2,
        TAP_CAP_DR = 4'h3,
        TAP_SHIFT_DR = 4'h4,
        TAP_EXIT1_DR = 4'h5,
        TAP_PAUSE_DR = 4'h6,
        TAP_EXIT2_DR = 4'h7,
        TAP_UPD_DR = 4'h8,
        TAP_SEL_IR = 4'h9,
        TAP_CAP_IR = 4'hA,
        TAP_SHIFT_IR = 4'hB,
        TAP_EXIT1_IR = 4'hC,
        TAP_PAUSE_IR = 4'hD,
        TAP_EXIT2_IR = 4'hE,
        TAP_UPD_IR = 4'hF
    } jpd_tap_e;

endpackage

/* File: jpd_skid.sv */
/*
 * jpd_skid: two-entry buffer with valid and ready on both sides;
 * the output side is registered.
 * assumes: both sides on clk; srst synchronous, active high.
 */
module jpd_skid #(
    parameter int W = jpd_pkg::LOAD_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [W-1:0] skid_data_reg;
    logic skid_valid_reg;
    logic take;

    // second entry only fills when the head is stalled
    assign in_ready = !skid_valid_reg;
    assign take = in_valid && in_ready;

    always_ff @(posedge clk) begin
        if (srst) begin
            out_valid <= 1'b0;
            out_data <= '0;
            skid_valid_reg <= 1'b0;
            skid_data_reg <= '0;
        end else if (!out_valid || out_ready) begin
            if (skid_valid_reg) begin
                out_data <= skid_data_reg;
                out_valid <= 1'b1;
                skid_valid_reg <= 1'b0;
            end else begin
                out_data <= in_data;
                out_valid <= take;
            end
        end else if (take) begin
            skid_data_reg <= in_data;
            skid_valid_reg <= 1'b1;
        end
    end
endmodule // jpd_skid

/* File: jpd_top.sv */
/*
 * jpd_top: test access port with the programming data registers
 * (device reset, unlock, command, page load, page read).
 * assumes: tck/tms/tdi arrive asynchronously and tck is well below
 * clk/4; command result and page read data come from logic on clk.
 */
// Behaviour
// - reset instruction selects one-bit reset register; port controller is untouched.
// - device held in reset while reset register holds one; no update latch.
// - reset register shifts one place per tck in Shift-DR.
// - unlock instruction selects 16-bit enable register; signature shifts in.
// - Update-DR compares signature; programming mode only on exact match.
// - command instruction selects 15-bit command register.
// - Capture-DR loads previous command result into command register.
// - Shift-DR shifts command in from tdi, result out on tdo.
// - Update-DR presents shifted command to memory control outputs.
// - Run-Test/Idle after command update gives one execute pulse.
// - page load is a virtual 1024-bit register built on 8-bit shifter.
// - page load moves each byte out during Shift-DR; Update-DR does nothing.
// - page read is a virtual 1032-bit register built on 8-bit shifter.
// - page read fetches bytes in Shift-DR, ignores tdi, no capture transfer.
// - unlock signature is the fixed 16-bit pattern A370 hex.
// - enable register clears to zero at reset.
// - all shift registers move least significant bit first.
// - instruction register is four bits wide.
module jpd_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    output logic device_reset_out,
    output logic prog_mode,
    output logic [14:0] cmd_word,
    output logic cmd_apply,
    output logic cmd_exec,
    input wire logic [14:0] cmd_result,
    output logic [7:0] load_data,
    output logic [6:0] load_index,
    output logic load_valid,
    input wire logic load_ready,
    output logic load_overrun,
    output logic read_req,
    output logic [6:0] read_index,
    input wire logic [7:0] read_data,
    input wire logic read_valid
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [2:0] tck_sync_reg;
    logic [1:0] tms_sync_reg;
    logic [1:0] tdi_sync_reg;
    logic tck_rise;
    logic tck_fall;
    logic tms_s;
    logic tdi_s;
    jpd_pkg::jpd_tap_e state_reg;
    logic [3:0] ir_shift_reg;
    logic [3:0] ir_reg;
    logic in_cap;
    logic in_shift;
    logic in_upd;
    logic rst_dr_reg;
    logic bypass_reg;
    logic [15:0] enable_reg;
    logic [14:0] cmd_shift_reg;
    logic cmd_pending_reg;
    logic [7:0] load_shift_reg;
    logic [7:0] read_shift_reg;
    logic [7:0] prefetch_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] idx_reg;
    logic [14:0] pend_data_reg;
    logic pend_valid_reg;
    logic pend_take;
    logic buf_in_ready;
    logic [14:0] buf_out_data;
    logic byte_done;
    logic [7:0] load_byte_next;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic jpd_pkg::jpd_tap_e tap_next(jpd_pkg::jpd_tap_e s, logic m);
        case (s)
            jpd_pkg::TAP_RESET: tap_next = m ? jpd_pkg::TAP_RESET : jpd_pkg::TAP_IDLE;
            jpd_pkg::TAP_IDLE: tap_next = m ? jpd_pkg::TAP_SEL_DR : jpd_pkg::TAP_IDLE;
            jpd_pkg::TAP_SEL_DR: tap_next = m ? jpd_pkg::TAP_SEL_IR : jpd_pkg::TAP_CAP_DR;
            jpd_pkg::TAP_CAP_DR: tap_next = m ? jpd_pkg::TAP_EXIT1_DR : jpd_pkg::TAP_SHIFT_DR;
            jpd_pkg::TAP_SHIFT_DR: tap_next = m ? jpd_pkg::TAP_EXIT1_DR : jpd_pkg::TAP_SHIFT_DR;
            jpd_pkg::TAP_EXIT1_DR: tap_next = m ? jpd_pkg::TAP_UPD_DR : jpd_pkg::TAP_PAUSE_DR;
            jpd_pkg::TAP_PAUSE_DR: tap_next = m ? jpd_pkg::TAP_EXIT2_DR : jpd_pkg::TAP_PAUSE_DR;
            jpd_pkg::TAP_EXIT2_DR: tap_next = m ? jpd_pkg::TAP_UPD_DR : jpd_pkg::TAP_SHIFT_DR;
            jpd_pkg::TAP_UPD_DR: tap_next = m ? jpd_pkg::TAP_SEL_DR : jpd_pkg::TAP_IDLE;
            jpd_pkg::TAP_SEL_IR: tap_next = m ? jpd_pkg::TAP_RESET : jpd_pkg::TAP_CAP_IR;
            jpd_pkg::TAP_CAP_IR: tap_next = m ? jpd_pkg::TAP_EXIT1_IR : jpd_pkg::TAP_SHIFT_IR;
            jpd_pkg::TAP_SHIFT_IR: tap_next = m ? jpd_pkg::TAP_EXIT1_IR : jpd_pkg::TAP_SHIFT_IR;
            jpd_pkg::TAP_EXIT1_IR: tap_next = m ? jpd_pkg::TAP_UPD_IR : jpd_pkg::TAP_PAUSE_IR;
            jpd_pkg::TAP_PAUSE_IR: tap_next = m ? jpd_pkg::TAP_EXIT2_IR : jpd_pkg::TAP_PAUSE_IR;
            jpd_pkg::TAP_EXIT2_IR: tap_next = m ? jpd_pkg::TAP_UPD_IR : jpd_pkg::TAP_SHIFT_IR;
            jpd_pkg::TAP_UPD_IR: tap_next = m ? jpd_pkg::TAP_SEL_DR : jpd_pkg::TAP_IDLE;
            default: tap_next = jpd_pkg::TAP_RESET;
        endcase
    endfunction

    // unknown codes fall back to the bypass bit
    function automatic logic dr_lsb(logic [3:0] ir, logic rst_b, logic byp_b, logic [15:0] en,
                                    logic [14:0] cmd, logic [7:0] ld, logic [7:0] rd);
        case (ir)
            jpd_pkg::IR_DEVICE_RESET: dr_lsb = rst_b;
            jpd_pkg::IR_UNLOCK: dr_lsb = en[0];
            jpd_pkg::IR_COMMAND: dr_lsb = cmd[0];
            jpd_pkg::IR_PAGE_LOAD: dr_lsb = ld[0];
            jpd_pkg::IR_PAGE_READ: dr_lsb = rd[0];
            default: dr_lsb = byp_b;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers and tck edges
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            tck_sync_reg <= 3'h0;
            tms_sync_reg <= 2'h3;
            tdi_sync_reg <= 2'h0;
        end else begin
            tck_sync_reg <= {tck_sync_reg[1:0], tck};
            tms_sync_reg <= {tms_sync_reg[0], tms};
            tdi_sync_reg <= {tdi_sync_reg[0], tdi};
        end
    end

    // third tck stage only serves edge detection
    assign tck_rise = tck_sync_reg[1] && !tck_sync_reg[2];
    assign tck_fall = !tck_sync_reg[1] && tck_sync_reg[2];
    assign tms_s = tms_sync_reg[1];
    assign tdi_s = tdi_sync_reg[1];
    assign in_cap = tck_rise && (state_reg == jpd_pkg::TAP_CAP_DR);
    assign in_shift = tck_rise && (state_reg == jpd_pkg::TAP_SHIFT_DR);
    assign in_upd = tck_rise && (state_reg == jpd_pkg::TAP_UPD_DR);

    // ----------------------------------------------------------------
    // port controller and instruction register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= jpd_pkg::TAP_RESET;
        end else if (tck_rise) begin
            state_reg <= tap_next(state_reg, tms_s);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ir_shift_reg <= jpd_pkg::IR_BYPASS;
            ir_reg <= jpd_pkg::IR_BYPASS;
        end else if (tck_rise) begin
            case (state_reg)
                jpd_pkg::TAP_RESET: begin
                    ir_reg <= jpd_pkg::IR_BYPASS;
                end
                jpd_pkg::TAP_CAP_IR: begin
                    ir_shift_reg <= jpd_pkg::IR_CAPTURE_VAL;
                end
                jpd_pkg::TAP_SHIFT_IR: begin
                    ir_shift_reg <= {tdi_s, ir_shift_reg[3:1]};
                end
                jpd_pkg::TAP_UPD_IR: begin
                    ir_reg <= ir_shift_reg;
                end
                default: begin
                    ir_reg <= ir_reg;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // reset and bypass registers
    // ----------------------------------------------------------------
    // the port controller keeps running while the device is held
    always_ff @(posedge clk) begin
        if (srst) begin
            rst_dr_reg <= 1'b0;
        end else if (in_shift && ir_reg == jpd_pkg::IR_DEVICE_RESET) begin
            rst_dr_reg <= tdi_s;
        end
    end

    assign device_reset_out = rst_dr_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            bypass_reg <= 1'b0;
        end else if (in_cap) begin
            bypass_reg <= 1'b0;
        end else if (in_shift) begin
            bypass_reg <= tdi_s;
        end
    end

    // ----------------------------------------------------------------
    // programming unlock
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            enable_reg <= jpd_pkg::ENABLE_RST;
        end else if (in_shift && ir_reg == jpd_pkg::IR_UNLOCK) begin
            enable_reg <= {tdi_s, enable_reg[15:1]};
        end
    end

    // a wrong signature also leaves programming mode
    always_ff @(posedge clk) begin
        if (srst) begin
            prog_mode <= 1'b0;
        end else if (in_upd && ir_reg == jpd_pkg::IR_UNLOCK) begin
            prog_mode <= (enable_reg == jpd_pkg::UNLOCK_SIGNATURE);
        end
    end

    // ----------------------------------------------------------------
    // programming command
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_shift_reg <= jpd_pkg::CMD_RST;
        end else if (ir_reg == jpd_pkg::IR_COMMAND) begin
            if (in_cap) begin
                cmd_shift_reg <= cmd_result;
            end else if (in_shift) begin
                cmd_shift_reg <= {tdi_s, cmd_shift_reg[14:1]};
            end
        end
    end

    // commands only reach the memory while unlocked
    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_word <= jpd_pkg::CMD_RST;
            cmd_apply <= 1'b0;
        end else begin
            cmd_apply <= 1'b0;
            if (in_upd && ir_reg == jpd_pkg::IR_COMMAND && prog_mode) begin
                cmd_word <= cmd_shift_reg;
                cmd_apply <= 1'b1;
            end
        end
    end

    // pending lives for one tck step; only a tck rise while in idle fires it
    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_pending_reg <= 1'b0;
            cmd_exec <= 1'b0;
        end else begin
            cmd_exec <= tck_rise && cmd_pending_reg && (state_reg == jpd_pkg::TAP_IDLE);
            if (in_upd) begin
                cmd_pending_reg <= (ir_reg == jpd_pkg::IR_COMMAND) && prog_mode;
            end else if (tck_rise) begin
                cmd_pending_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // page byte counters (shared by load and read)
    // ----------------------------------------------------------------
    assign byte_done = in_shift && (bit_cnt_reg == jpd_pkg::LAST_BIT);

    always_ff @(posedge clk) begin
        if (srst) begin
            bit_cnt_reg <= 3'h0;
            idx_reg <= 7'h00;
        end else if (in_cap) begin
            bit_cnt_reg <= 3'h0;
            idx_reg <= 7'h00;
        end else if (in_shift) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == jpd_pkg::LAST_BIT) begin
                idx_reg <= idx_reg + 7'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // page load
    // ----------------------------------------------------------------
    assign load_byte_next = {tdi_s, load_shift_reg[7:1]};

    always_ff @(posedge clk) begin
        if (srst) begin
            load_shift_reg <= 8'h00;
        end else if (in_shift && ir_reg == jpd_pkg::IR_PAGE_LOAD) begin
            load_shift_reg <= load_byte_next;
        end
    end

    // a finished byte waits here until the buffer takes it; a whole
    // byte time is spare, so only a long receiver stall overruns
    assign pend_take = pend_valid_reg && buf_in_ready;

    always_ff @(posedge clk) begin
        if (srst) begin
            pend_valid_reg <= 1'b0;
            pend_data_reg <= 15'h0000;
        end else if (byte_done && ir_reg == jpd_pkg::IR_PAGE_LOAD && prog_mode) begin
            pend_valid_reg <= 1'b1;
            pend_data_reg <= {idx_reg, load_byte_next};
        end else if (pend_take) begin
            pend_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            load_overrun <= 1'b0;
        end else if (in_cap && ir_reg == jpd_pkg::IR_PAGE_LOAD) begin
            load_overrun <= 1'b0;
        end else if (byte_done && ir_reg == jpd_pkg::IR_PAGE_LOAD && pend_valid_reg && !pend_take) begin
            load_overrun <= 1'b1;
        end
    end

    jpd_skid #(
        .W(jpd_pkg::LOAD_W)
    ) u_load_buf (
        .clk(clk),
        .srst(srst),
        .in_data(pend_data_reg),
        .in_valid(pend_valid_reg),
        .in_ready(buf_in_ready),
        .out_data(buf_out_data),
        .out_valid(load_valid),
        .out_ready(load_ready)
    );

    assign load_data = buf_out_data[7:0];
    assign load_index = buf_out_data[14:8];

    // ----------------------------------------------------------------
    // page read
    // ----------------------------------------------------------------
    // fetch starts at the first bit of each byte, leaving seven tck
    // periods for the answer; the filler byte covers the first fetch
    always_ff @(posedge clk) begin
        if (srst) begin
            read_req <= 1'b0;
            read_index <= 7'h00;
        end else begin
            read_req <= 1'b0;
            if (in_shift && ir_reg == jpd_pkg::IR_PAGE_READ && bit_cnt_reg == 3'h0 && prog_mode) begin
                read_req <= 1'b1;
                read_index <= idx_reg;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prefetch_reg <= 8'h00;
        end else if (read_valid) begin
            prefetch_reg <= read_data;
        end
    end

    // capture leaves the shifter alone except for the filler byte
    always_ff @(posedge clk) begin
        if (srst) begin
            read_shift_reg <= jpd_pkg::READ_FILL_BYTE;
        end else if (ir_reg == jpd_pkg::IR_PAGE_READ) begin
            if (in_cap) begin
                read_shift_reg <= jpd_pkg::READ_FILL_BYTE;
            end else if (byte_done) begin
                read_shift_reg <= prefetch_reg;
            end else if (in_shift) begin
                read_shift_reg <= {1'b0, read_shift_reg[7:1]};
            end
        end
    end

    // ----------------------------------------------------------------
    // tdo, changed on the falling tck edge
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= (state_reg == jpd_pkg::TAP_SHIFT_DR) || (state_reg == jpd_pkg::TAP_SHIFT_IR);
            if (state_reg == jpd_pkg::TAP_SHIFT_IR) begin
                tdo <= ir_shift_reg[0];
            end else begin
                tdo <= dr_lsb(ir_reg, rst_dr_reg, bypass_reg, enable_reg,
                              cmd_shift_reg, load_shift_reg, read_shift_reg);
            end
        end
    end
endmodule // jpd_top

/* File: jpd_top_properties.sv */
/* jpd_props: port checks on jpd_top; assumes it is bound into jpd_top, clk only, srst synchronous. */
module jpd_props (
    input wire logic clk,
    input wire logic srst,
    input wire logic tdo_oe,
    input wire logic device_reset_out,
    input wire logic prog_mode,
    input wire logic [14:0] cmd_word,
    input wire logic cmd_apply,
    input wire logic cmd_exec,
    input wire logic [7:0] load_data,
    input wire logic [6:0] load_index,
    input wire logic load_valid,
    input wire logic load_ready,
    input wire logic read_req
);
    // --------
    // checks
    // --------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_apply_pulse: assert property (cmd_apply |=> !cmd_apply) else $error("apply too long");
    a_word_apply: assert property ($changed(cmd_word) |-> cmd_apply) else $error("word moved alone");
    a_apply_unlocked: assert property (cmd_apply |-> prog_mode) else $error("apply while locked");
    a_exec_pulse: assert property (cmd_exec |=> !cmd_exec) else $error("exec too long");
    a_exec_after: assert property (cmd_exec |-> $past(cmd_apply, 7) || $past(cmd_apply, 8) || $past(cmd_apply, 9))
        else $error("exec not one tck after apply");
    a_read_pulse: assert property (read_req |=> !read_req) else $error("fetch too long");
    // a stalled byte must not move, or the page buffer gets a gap
    a_load_hold: assert property (load_valid && !load_ready |=>
        load_valid && $stable({load_data, load_index})) else $error("byte changed in stall");
    a_reset_shift: assert property ($changed(device_reset_out) |-> $past(tdo_oe))
        else $error("reset bit moved outside shift");
endmodule // jpd_props
bind jpd_top jpd_props i_jpd_props (.clk(clk), .srst(srst), .tdo_oe(tdo_oe), .device_reset_out(device_reset_out),
    .prog_mode(prog_mode), .cmd_word(cmd_word), .cmd_apply(cmd_apply), .cmd_exec(cmd_exec), .load_data(load_data),
    .load_index(load_index), .load_valid(load_valid), .load_ready(load_ready), .read_req(read_req));

/* File: jpd_prog.sv */
/* jpd_prog: test-port programmer model; assumes it is the only device on the chain. */
module jpd_prog (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------
    // link
    // ------
    initial {tck, tms, tdi} = 3'b010; // tck stands low between frames
    // tdo read late in the high phase, clear of its update after the fall
    task automatic step(input logic m, input logic b, output logic o);
        tms = m;
        tdi = b;
        #160 tck = 1'b1;
        #150 o = tdo;
        #10 tck = 1'b0;
    endtask
    // tdi is don't-care here, so it toggles instead of holding
    task automatic mv(input logic m);
        logic o;
        step(m, ~tdi, o);
    endtask
    task automatic tap_reset();
        repeat (5) mv(1'b1);
        mv(1'b0);
    endtask
    // sole device on the chain, so page scans are allowed
    task automatic scan(input logic ir, input int n, input logic [1031:0] din, input logic idle,
        output logic [1031:0] dout);
        dout = '0;
        mv(1'b1);
        if (ir) mv(1'b1);
        mv(1'b0);
        mv(1'b0);
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
        mv(1'b1);
        if (!idle) repeat (3) mv(1'b1);
        mv(1'b0);
        mv(1'b0); // one tck in idle carries the execute clock
    endtask
endmodule // jpd_prog

/* File: jpd_top_test.sv */
/* jpd_top_test: bench for jpd_top; assumes jpd_pkg, jpd_top, jpd_prog, jpd_props compiled first. */
module jpd_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    // --------
    // harness
    // --------
    logic clk = 1'b0, srst = 1'b1, load_ready = 1'b0, read_valid = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe, device_reset_out, prog_mode, cmd_apply, cmd_exec, load_valid, load_overrun, read_req;
    logic [14:0] cmd_word, cmd_result = 15'h2A5A;
    logic [7:0] load_data, read_data = 8'h00;
    logic [7:0] got [128];
    logic [6:0] load_index, read_index;
    logic [1031:0] q, d;
    int miscompares = 0, checks = 0, n_exec = 0, n_apply = 0, n_load = 0;
    always #20 clk = ~clk;
    jpd_prog i_jpd_prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    jpd_top i_jpd_top (.clk(clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .device_reset_out(device_reset_out), .prog_mode(prog_mode), .cmd_word(cmd_word), .cmd_apply(cmd_apply),
        .cmd_exec(cmd_exec), .cmd_result(cmd_result), .load_data(load_data), .load_index(load_index),
        .load_valid(load_valid), .load_ready(load_ready), .load_overrun(load_overrun), .read_req(read_req),
        .read_index(read_index), .read_data(read_data), .read_valid(read_valid));
    // consumer stalls half of every 640 ns; idle read data never stands still
    always @(negedge clk) begin
        read_valid <= read_req;
        read_data <= read_req ? {1'b0, read_index} ^ 8'h3C : ~read_data;
        load_ready <= ($time % 640) < 320;
    end
    always @(posedge clk) begin
        n_exec <= n_exec + int'(cmd_exec);
        n_apply <= n_apply + int'(cmd_apply);
        n_load <= n_load + int'(load_valid && load_ready);
        if (load_valid && load_ready) got[load_index] <= load_data;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic t_devreset();
        i_jpd_prog.tap_reset();
        i_jpd_prog.scan(1'b1, 4, 1032'hC, 1'b1, q);
        chk("ir capture", 16'h0001, q[15:0]);
        i_jpd_prog.scan(1'b0, 1, 1032'h1, 1'b1, q);
        chk("reset held", 16'h0001, {15'h0, device_reset_out});
        i_jpd_prog.scan(1'b0, 1, 1032'h0, 1'b1, q);
        chk("reset out bit", 16'h0001, q[15:0]);
        chk("reset free", 16'h0000, {15'h0, device_reset_out});
        i_jpd_prog.scan(1'b1, 4, 1032'hF, 1'b1, q);
        i_jpd_prog.scan(1'b0, 2, 1032'h3, 1'b1, q);
        chk("bypass", 16'h0002, q[15:0]);
        $display("test device reset done");
    endtask
    task automatic t_unlock();
        chk("locked", 16'h0000, {15'h0, prog_mode});
        i_jpd_prog.scan(1'b1, 4, 1032'h4, 1'b1, q);
        i_jpd_prog.scan(1'b0, 16, 1032'h0EC5, 1'b1, q);
        chk("reversed sig", 16'h0000, {15'h0, prog_mode});
        i_jpd_prog.scan(1'b0, 16, 1032'hA370, 1'b1, q);
        chk("signature", 16'h0001, {15'h0, prog_mode});
        $display("test unlock done");
    endtask
    task automatic t_command();
        i_jpd_prog.scan(1'b1, 4, 1032'h5, 1'b1, q);
        i_jpd_prog.scan(1'b0, 15, 1032'h1234, 1'b1, q);
        chk("result", 16'h2A5A, q[15:0]);
        chk("command", 16'h1234, {1'b0, cmd_word});
        chk("exec", 16'h0001, 16'(n_exec));
        @(negedge clk) cmd_result = 15'h3C3C;
        i_jpd_prog.scan(1'b0, 15, 1032'h0777, 1'b0, q);
        chk("result 2", 16'h3C3C, q[15:0]);
        chk("no exec", 16'h0001, 16'(n_exec));
        chk("applies", 16'h0002, 16'(n_apply));
        $display("test command done");
    endtask
    task automatic t_pageload();
        for (int k = 0; k < 128; k++) d[8 * k +: 8] = 8'(k) ^ 8'hA5;
        i_jpd_prog.scan(1'b1, 4, 1032'h6, 1'b1, q);
        i_jpd_prog.scan(1'b0, 1024, d, 1'b1, q);
        for (int i = 0; i < 100 && n_load < 128; i++) @(negedge clk);
        chk("bytes moved", 16'h0080, 16'(n_load));
        for (int k = 0; k < 128; k++) chk("load byte", 16'(8'(k) ^ 8'hA5), {8'h00, got[k]});
        chk("overrun", 16'h0000, {15'h0, load_overrun});
        $display("test page load done");
    endtask
    task automatic t_pageread();
        i_jpd_prog.scan(1'b1, 4, 1032'h7, 1'b1, q);
        i_jpd_prog.scan(1'b0, 1032, '1, 1'b1, q);
        chk("filler", 16'h0000, {8'h00, q[7:0]});
        for (int k = 0; k < 128; k++) chk("read byte", 16'(8'(k) ^ 8'h3C), {8'h00, q[8 * k + 8 +: 8]});
        i_jpd_prog.scan(1'b1, 4, 1032'h4, 1'b1, q);
        i_jpd_prog.scan(1'b0, 16, 1032'h0, 1'b1, q);
        chk("relocked", 16'h0000, {15'h0, prog_mode});
        i_jpd_prog.scan(1'b1, 4, 1032'h5, 1'b1, q);
        i_jpd_prog.scan(1'b0, 15, 1032'h0111, 1'b1, q);
        chk("locked apply", 16'h0002, 16'(n_apply));
        chk("locked word", 16'h0777, {1'b0, cmd_word});
        chk("locked exec", 16'h0001, 16'(n_exec));
        $display("test page read done");
    endtask
    initial begin
        repeat (3) @(negedge clk);
        srst = 1'b0;
        t_devreset();
        t_unlock();
        t_command();
        t_pageload();
        t_pageread();
        results();
    end
    // two page scans of about 330 us each dominate the run
    initial begin
        #1500000;
        miscompares++;
        results();
    end
endmodule // jpd_top_test
